// *** spdtx_pkg.sv ***
package spdtx_pkg;

  localparam int unsigned SPDTX_MAX_W      = 24;
  localparam int unsigned SPDTX_FIFO_DEPTH = 32;

  localparam logic [1:0] SPDTX_FMT_I2S = 2'h0;
  localparam logic [1:0] SPDTX_FMT_LJ  = 2'h1;
  localparam logic [1:0] SPDTX_FMT_RJ  = 2'h2;

  localparam logic [1:0] SPDTX_W16 = 2'h0;
  localparam logic [1:0] SPDTX_W18 = 2'h1;
  localparam logic [1:0] SPDTX_W20 = 2'h2;
  localparam logic [1:0] SPDTX_W24 = 2'h3;

  localparam logic SPDTX_OSR_256 = 1'h0;
  localparam logic SPDTX_OSR_384 = 1'h1;

  localparam logic [1:0] SPDTX_DIV_256 = 2'h2;
  localparam logic [1:0] SPDTX_DIV_384 = 2'h3;

  localparam logic [5:0] SPDTX_CNT_MAX   = 6'h3F;
  localparam logic [5:0] SPDTX_I2S_START = 6'h01;
  localparam logic [5:0] SPDTX_LJ_START  = 6'h00;

  typedef struct packed {
    logic [1:0] fmt;
    logic [1:0] width;
    logic       osr;
  } spdtx_cfg_s;

  typedef struct packed {
    logic [SPDTX_MAX_W-1:0] left;
    logic [SPDTX_MAX_W-1:0] right;
  } spdtx_pair_s;

  typedef struct packed {
    logic [1:0]             bclk_s;
    logic [1:0]             lr_s;
    logic [1:0]             dat_s;
    logic [1:0]             ovs_s;
    logic                   bclk_d;
    logic                   lr_d;
    logic                   ovs_d;
    logic [5:0]             bit_cnt;
    logic [SPDTX_MAX_W-1:0] sh;
    logic [SPDTX_MAX_W-1:0] left;
    logic                   have_left;
    logic                   pend;
    spdtx_pair_s            pair;
    logic                   overrun;
    logic [1:0]             div_cnt;
    logic                   biphase;
  } spdtx_state_s;

  // The bit clock detector starts high, so a clock parked high at release is no edge.
  localparam spdtx_state_s SPDTX_ST_RST = '{bclk_s: 2'h3, bclk_d: 1'h1, default: '0};

endpackage

// *** spdtx_serial_in.sv ***
// Functional notes
// - Accept RJ, I2S, LJ; widths 16 to 24.
// - RJ: channel select high is left.
// - Capture data on rising bit clock edge.
// - RJ: MSB starts 32 minus width late.
// - RJ: LSB ends at next select transition.
// - I2S default: select low is left.
// - I2S: MSB one bit clock after transition.
// - LJ: select high left, MSB at transition.
// - Biphase clock divided from oversampling clock.
`timescale 1ns/1ps
`default_nettype none

module spdtx_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic      [WIDTH-1:0] rd_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } spdtx_fifo_state_s;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("spdtx_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0]  mem [DEPTH];
  spdtx_fifo_state_s st_reg;
  spdtx_fifo_state_s st_next;
  logic              full;
  logic              empty;
  logic              push;
  logic              pop;

  assign full       = (st_reg.wp[AW] != st_reg.rp[AW]) && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
  assign empty      = (st_reg.wp == st_reg.rp);
  assign wr_ready_o = ~full;
  assign rd_valid_o = ~empty;
  assign rd_data_o  = mem[st_reg.rp[AW-1:0]];
  assign push       = wr_valid_i & ~full & clk_en_i;
  assign pop        = rd_ready_i & ~empty & clk_en_i;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop)
    begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '0;
    end
    else if (clk_en_i)
    begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[st_reg.wp[AW-1:0]] <= wr_data_i;
    end
  end
endmodule

module spdtx_serial_in
  import spdtx_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = SPDTX_FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        bit_clk_i,
  input  wire logic        ch_sel_i,
  input  wire logic        data_i,
  input  wire logic        oversampling_clock_i,
  input  wire spdtx_cfg_s  cfg_i,
  output logic             biphase_clk_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output spdtx_pair_s      out_pair_o,
  output logic             overrun_o
);
  spdtx_state_s st_reg;
  spdtx_state_s st_next;
  logic         wr_ready;

  function automatic logic [5:0] width_bits(input logic [1:0] code);
    case (code)
      SPDTX_W16: width_bits = 6'h10;
      SPDTX_W18: width_bits = 6'h12;
      SPDTX_W20: width_bits = 6'h14;
      default:   width_bits = 6'h18;
    endcase
  endfunction

  // Words leave MSB-aligned in 24 bits so the encoder sees one format for all widths.
  function automatic logic [SPDTX_MAX_W-1:0] align_word(input logic [SPDTX_MAX_W-1:0] src,
                                                        input logic [1:0]             code);
    logic [5:0] w;
    w          = width_bits(code);
    align_word = src << (6'h18 - w);
  endfunction

  always_comb
  begin
    logic                   rise;
    logic                   bit_now;
    logic                   lr_now;
    logic                   trans;
    logic [5:0]             cnt_now;
    logic [5:0]             start;
    logic                   done;
    logic                   is_left;
    logic [SPDTX_MAX_W-1:0] src;
    logic [SPDTX_MAX_W-1:0] word;
    logic [1:0]             div;
    rise    = 1'b0;
    bit_now = 1'b0;
    lr_now  = 1'b0;
    trans   = 1'b0;
    cnt_now = 6'h00;
    start   = 6'h00;
    done    = 1'b0;
    is_left = 1'b0;
    src     = '0;
    word    = '0;
    div     = 2'h0;
    st_next = st_reg;

    // The first stage of every synchroniser feeds only its second stage.
    st_next.bclk_s = {st_reg.bclk_s[0], bit_clk_i};
    st_next.lr_s   = {st_reg.lr_s[0], ch_sel_i};
    st_next.dat_s  = {st_reg.dat_s[0], data_i};
    st_next.ovs_s  = {st_reg.ovs_s[0], oversampling_clock_i};
    st_next.bclk_d = st_reg.bclk_s[1];
    st_next.ovs_d  = st_reg.ovs_s[1];

    if (st_reg.pend && wr_ready)
    begin
      st_next.pend = 1'b0;
    end

    rise = st_reg.bclk_s[1] & ~st_reg.bclk_d;
    if (rise)
    begin
      bit_now        = st_reg.dat_s[1];
      lr_now         = st_reg.lr_s[1];
      trans          = (lr_now != st_reg.lr_d);
      st_next.lr_d   = lr_now;
      cnt_now        = trans ? 6'h00 :
                       (st_reg.bit_cnt == SPDTX_CNT_MAX) ? SPDTX_CNT_MAX : st_reg.bit_cnt + 6'h01;
      st_next.bit_cnt = cnt_now;
      st_next.sh      = {st_reg.sh[SPDTX_MAX_W-2:0], bit_now};
      case (cfg_i.fmt)
        SPDTX_FMT_RJ:
        begin
          // The last width bits before the transition are the word, so the MSB
          // lands 32 minus width bits in on a 64-bit frame.
          done    = trans;
          is_left = st_reg.lr_d;
          src     = st_reg.sh;
        end
        SPDTX_FMT_LJ:
        begin
          start   = SPDTX_LJ_START;
          done    = (cnt_now == start + width_bits(cfg_i.width) - 6'h01);
          is_left = lr_now;
          src     = {st_reg.sh[SPDTX_MAX_W-2:0], bit_now};
        end
        default:
        begin
          start   = SPDTX_I2S_START;
          done    = (cnt_now == start + width_bits(cfg_i.width) - 6'h01);
          is_left = ~lr_now;
          src     = {st_reg.sh[SPDTX_MAX_W-2:0], bit_now};
        end
      endcase
      word = align_word(src, cfg_i.width);
    end

    if (done)
    begin
      if (is_left)
      begin
        st_next.left      = word;
        st_next.have_left = 1'b1;
      end
      else if (st_reg.have_left)
      begin
        st_next.have_left = 1'b0;
        // A pair that finds the previous one still waiting is dropped and flagged.
        if (st_next.pend)
        begin
          st_next.overrun = 1'b1;
        end
        else
        begin
          st_next.pair = '{left: st_reg.left, right: word};
          st_next.pend = 1'b1;
        end
      end
    end

    // Both edges count, so 256 fs divides by 2 and 384 fs by 3 to 128 fs.
    div = (cfg_i.osr == SPDTX_OSR_384) ? SPDTX_DIV_384 : SPDTX_DIV_256;
    if (st_reg.ovs_s[1] != st_reg.ovs_d)
    begin
      if (st_reg.div_cnt >= div - 2'h1)
      begin
        st_next.div_cnt = 2'h0;
        st_next.biphase = ~st_reg.biphase;
      end
      else
      begin
        st_next.div_cnt = st_reg.div_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= SPDTX_ST_RST;
    end
    else if (clk_en_i)
    begin
      st_reg <= st_next;
    end
  end

  spdtx_fifo #(
    .WIDTH ($bits(spdtx_pair_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .wr_valid_i (st_reg.pend),
    .wr_ready_o (wr_ready),
    .wr_data_i  (st_reg.pair),
    .rd_valid_o (out_valid_o),
    .rd_ready_i (out_ready_i),
    .rd_data_o  (out_pair_o)
  );

  assign biphase_clk_o = st_reg.biphase;
  assign overrun_o     = st_reg.overrun;
endmodule

`default_nettype wire

// *** spdtx_serial_in_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module spdtx_serial_in_chk
  import spdtx_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  input wire logic        oversampling_clock_i,
  input wire logic        out_ready_i,
  input wire logic        out_valid_o,
  input wire spdtx_pair_s out_pair_o,
  input wire logic        overrun_o,
  input wire logic        biphase_clk_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Eight quiet cycles flush the edge synchroniser, so the divider must rest.
  sequence s_ovs_quiet;
    (clk_en_i && $stable(oversampling_clock_i)) [*8];
  endsequence
  a_reset_clear: assert property (disable iff (1'h0)
    !rst_n_i |=> !biphase_clk_o && !out_valid_o && !overrun_o) else $error("reset ignored");
  a_bip_hold: assert property ($changed(biphase_clk_o) |=>
    $stable(biphase_clk_o) [*3]) else $error("biphase too fast");
  a_bip_idle: assert property (s_ovs_quiet |=> $stable(biphase_clk_o))
    else $error("biphase free running");
  a_freeze_all: assert property (!clk_en_i |=> $stable(biphase_clk_o) &&
    $stable(out_valid_o) && $stable(overrun_o)) else $error("moved while frozen");
  a_valid_hold: assert property (out_valid_o && !(out_ready_i && clk_en_i) |=>
    out_valid_o && $stable(out_pair_o)) else $error("pair lost");
  a_pop_only: assert property ($fell(out_valid_o) |->
    $past(out_ready_i && clk_en_i)) else $error("valid fell without pop");
  a_ovr_sticky: assert property (overrun_o |=> overrun_o)
    else $error("overrun cleared");
  a_ovr_full: assert property ($rose(overrun_o) |-> out_valid_o)
    else $error("overrun while empty");
endmodule
bind spdtx_serial_in spdtx_serial_in_chk u_chk (.clk_i, .rst_n_i, .clk_en_i,
  .oversampling_clock_i, .out_ready_i, .out_valid_o, .out_pair_o, .overrun_o, .biphase_clk_o);
`default_nettype wire

// *** spdtx_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spdtx_src_model
  import spdtx_pkg::*;
(
  input  wire logic clk_i,
  output logic      bit_clk_o,
  output logic      ch_sel_o,
  output logic      data_o
);
  initial
  begin
    bit_clk_o = 1'h0;
    ch_sel_o  = 1'h0;
    data_o    = 1'h0;
  end
  function automatic logic left_lvl(input logic [1:0] f);
    return f == SPDTX_FMT_LJ || f == SPDTX_FMT_RJ;
  endfunction
  // Unused slots carry a toggling filler so a late capture cannot pass by luck.
  function automatic logic pick(input logic [1:0] f, input int n, input int k,
                                input logic [23:0] v);
    int i;
    i = f == SPDTX_FMT_RJ ? k + n - 32 : f == SPDTX_FMT_LJ ? k : k - 1;
    return (i >= 0 && i < n) ? v[23 - i] : ~data_o;
  endfunction
  task automatic bit_out(input logic lr, input logic d);
    @(posedge clk_i) #1;
    bit_clk_o = 1'h0;
    ch_sel_o  = lr;
    data_o    = d;
    repeat (4) @(posedge clk_i);
    #1 bit_clk_o = 1'h1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pad(input logic [1:0] f, input logic lft);
    bit_out(left_lvl(f) ^ !lft, ~data_o);
  endtask
  task automatic frame(input logic [1:0] f, input logic [1:0] w, input logic [23:0] l, r);
    int n;
    n = (w == SPDTX_W24) ? 24 : 16 + 2 * w;
    for (int c = 0; c < 64; c++)
      bit_out(left_lvl(f) ^ (c > 31), pick(f, n, c % 32, c > 31 ? r : l));
  endtask
endmodule
`default_nettype wire

// *** spdtx_serial_in_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module spdtx_serial_in_tb
  import spdtx_pkg::*;
;
  logic        clk_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic        clk_en_i = 1'h1;
  logic        ovs = 1'h0;
  logic        out_ready_i = 1'h0;
  spdtx_cfg_s  cfg = 5'h00;
  logic        bit_clk, ch_sel, data, bip, valid, overrun;
  spdtx_pair_s pair;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #2.5 clk_i = ~clk_i;
  spdtx_serial_in dut (.clk_i, .rst_n_i, .clk_en_i, .bit_clk_i (bit_clk), .ch_sel_i (ch_sel),
    .data_i (data), .oversampling_clock_i (ovs), .cfg_i (cfg), .biphase_clk_o (bip),
    .out_valid_o (valid), .out_ready_i, .out_pair_o (pair), .overrun_o (overrun));
  spdtx_src_model src (.clk_i, .bit_clk_o (bit_clk), .ch_sel_o (ch_sel), .data_o (data));
  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // The lead bit gives every format a clean channel edge before its first word.
  task automatic do_reset(input spdtx_cfg_s c);
    @(posedge clk_i) #1;
    rst_n_i = 1'h0;
    cfg     = c;
    repeat (10) @(posedge clk_i);
    #1 rst_n_i = 1'h1;
    src.pad(c.fmt, 1'h0);
  endtask
  function automatic logic [23:0] msk(input logic [1:0] w);
    return 24'hFFFFFF << ((w == SPDTX_W24) ? 0 : 8 - 2 * w);
  endfunction
  // Format code 3 is unnamed and must behave as the default format.
  task automatic t_formats();
    logic [23:0] l;
    logic [47:0] e;
    for (int f = 0; f < 4; f++)
      for (int w = 0; w < 4; w++)
      begin
        l = {8'hA0 + 8'(4 * f + w), 16'h5A3C};
        e = {l & msk(w[1:0]), ~l & msk(w[1:0])};
        do_reset({f[1:0], w[1:0], SPDTX_OSR_256});
        src.frame(f[1:0], w[1:0], l, ~l);
        src.pad(f[1:0], 1'h1);
        for (int k = 0; k < 40 && valid !== 1'h1; k++)
          @(posedge clk_i) #1;
        `CHK(pair, e)
      end
  endtask
  task automatic t_bip(input logic osr, input int per);
    int last;
    int n;
    logic b;
    do_reset({SPDTX_FMT_I2S, SPDTX_W16, osr});
    #1;
    last = 0;
    n = 0;
    b = bip;
    for (int c = 1; c < 200; c++)
    begin
      ovs = (c % 8) < 4;
      @(posedge clk_i) #1;
      if (bip !== b)
      begin
        if (n > 0)
          `CHK(c - last, per)
        n++;
        last = c;
        b = bip;
      end
    end
    `CHK(n > 10, 1'h1)
  endtask
  task automatic t_fill();
    do_reset({SPDTX_FMT_LJ, SPDTX_W24, SPDTX_OSR_256});
    for (int i = 0; i < 34; i++)
    begin
      src.frame(SPDTX_FMT_LJ, SPDTX_W24, 24'(i), 24'(~i));
      if (i == 32)
        `CHK(overrun, 1'h0)
    end
    `CHK(overrun, 1'h1)
    #1 clk_en_i = 1'h0;
    out_ready_i = 1'h1;
    repeat (3) @(posedge clk_i) #1;
    clk_en_i = 1'h1;
    for (int i = 0; i < 33; i++)
    begin
      `CHK(pair, {24'(i), 24'(~i)})
      @(posedge clk_i) #1;
    end
    `CHK(valid, 1'h0)
    out_ready_i = 1'h0;
  endtask
  initial
  begin
    t_formats();
    t_bip(SPDTX_OSR_256, 8);
    t_bip(SPDTX_OSR_384, 12);
    t_fill();
    end_of_test();
  end
endmodule
`default_nettype wire
